// >>> host_port_interface_tb.sv
// Self-checking bench for the host port in 16-bit and 8-bit modes
`timescale 1ns/1ps
`default_nettype none
module host_port_interface_tb;
    logic clk, rst, width_sel, cs_n, ds1_n, ds2_n, rw, half, hbh_en, core_wr, core_req;
    logic hd_oe, rdy, hirq_n, holder, core_irq, stall, dreq, dwe, dack, bo;
    logic [1:0] csel;
    logic [3:0] mem_delay;
    logic [14:0] core_addr, daddr;
    logic [15:0] haddr, hdata, core_data, hd_out, core_ctl, dwdata, drdata, last_wd, q;
    logic [15:0] shadow [logic [14:0]];
    logic [14:0] aq [$];
    int n_mismatch, num_checks, s0;
    int n_stall = 0;

    hpi_port i_hpi_port (
        .clk_in(clk), .rst_in(rst), .width_select_pin_in(width_sel),
        .host_chip_select_n_in(cs_n), .host_data_strobe_one_n_in(ds1_n),
        .host_data_strobe_two_n_in(ds2_n), .host_rw_direction_in(rw),
        .byte_half_select_in(half), .host_control_select_in(csel),
        .host_address_bus_in(haddr), .host_data_bus_in(hdata), .host_data_bus_out(hd_out),
        .host_data_bus_oe_out(hd_oe), .host_wait_ready_out(rdy), .host_irq_n_out(hirq_n),
        .host_bus_holder_out(holder), .host_bus_holder_enable_in(hbh_en),
        .core_ctl_wr_in(core_wr), .core_ctl_data_in(core_data), .core_ctl_out(core_ctl),
        .core_irq_out(core_irq), .core_req_in(core_req), .core_addr_in(core_addr),
        .core_stall_out(stall), .dma_req_out(dreq), .dma_we_out(dwe), .dma_addr_out(daddr),
        .dma_wdata_out(dwdata), .dma_ack_in(dack), .dma_rdata_in(drdata)
    );
    hpi_mem_model i_hpi_mem_model (
        .clk_in(clk), .rst_in(rst), .req_in(dreq), .we_in(dwe), .addr_in(daddr),
        .wdata_in(dwdata), .delay_in(mem_delay), .ack_out(dack), .rdata_out(drdata)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (stall === 1'b1) n_stall <= n_stall + 1;
        if (dreq === 1'b1 && dwe === 1'b1) last_wd <= dwdata;
    end

    // =====================================
    // Checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_rdy(input logic val);
        int i;
        i = 0;
        while (rdy !== val) begin
            @(negedge clk);
            i++;
            if (i > 60) begin
                n_mismatch++;
                $display("mismatch at %0t: ready wait ran out", $time);
                report_and_stop();
            end
        end
    endtask

    // =====================================
    // Host cycles
    task automatic do_reset(input logic w);
        @(posedge clk);
        rst <= 1'b1;
        width_sel <= w;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({14'h0, rdy, hirq_n}, 16'h3);
        check({14'h0, dreq, hd_oe}, 16'h0);
        @(posedge clk);
    endtask
    task automatic access16(input logic rd, input logic [15:0] a, input logic [15:0] d);
        logic two;
        two = 1'($urandom % 2);
        @(posedge clk);
        cs_n <= 1'b0;
        ds1_n <= two;
        ds2_n <= ~two;
        rw <= rd;
        haddr <= a;
        hdata <= d;
        csel <= 2'($urandom);
        mem_delay <= 4'($urandom % 6);
        wait_rdy(1'b0);
        check({14'h0, dreq, dwe}, {14'h0, 1'b1, ~rd});
        check({1'b0, daddr}, {1'b0, a[14:0]});
        if (!rd) check(dwdata, d);
        wait_rdy(1'b1);
        if (rd) check(hd_out, d);
        if (rd) check({15'h0, hd_oe}, 16'h1);
        @(posedge clk);
        cs_n <= 1'b1;
        ds1_n <= 1'b1;
        ds2_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic byte_acc(input logic [1:0] sel, input logic hb, input logic rd,
                            input logic [7:0] d, output logic [7:0] b);
        @(posedge clk);
        cs_n <= 1'b0;
        ds1_n <= 1'b0;
        rw <= rd;
        csel <= sel;
        half <= hb;
        hdata <= {8'($urandom), d};
        repeat (5) @(negedge clk);
        b = hd_out[7:0];
        @(posedge clk);
        cs_n <= 1'b1;
        ds1_n <= 1'b1;
        wait_rdy(1'b1);
        repeat (4) @(posedge clk);
    endtask
    task automatic word8(input logic [1:0] sel, input logic rd, input logic [15:0] w);
        logic [7:0] b0, b1;
        byte_acc(sel, 1'b0, rd, bo ? w[15:8] : w[7:0], b0);
        byte_acc(sel, 1'b1, rd, bo ? w[7:0] : w[15:8], b1);
        q = bo ? {b0, b1} : {b1, b0};
    endtask
    task automatic core_write(input logic [15:0] d);
        @(posedge clk);
        core_wr <= 1'b1;
        core_data <= d;
        @(posedge clk);
        core_wr <= 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // =====================================
    // Main sequence
    initial begin
        {rst, width_sel, cs_n, ds1_n, ds2_n, rw} = 6'h3f;
        {half, hbh_en, core_wr, core_req, bo} = 5'h0;
        {csel, mem_delay, core_addr} = '0;
        {haddr, hdata, core_data} = '0;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(32'h9119c074));
        do_reset(1'b1);
        @(negedge clk);
        check({15'h0, holder}, 16'h1);
        @(posedge clk);
        cs_n <= 1'b1;
        ds1_n <= 1'b0;
        repeat (8) begin
            @(negedge clk);
            check({15'h0, dreq}, 16'h0);
        end
        @(posedge clk);
        ds1_n <= 1'b1;
        aq = '{15'h0000, 15'h7ffe, 15'h7fff};
        repeat (9) aq.push_back(15'($urandom));
        foreach (aq[i]) begin
            shadow[aq[i]] = 16'($urandom);
            access16(1'b0, {1'($urandom), aq[i]}, shadow[aq[i]]);
        end
        foreach (aq[i]) access16(1'b1, {1'($urandom), aq[i]}, shadow[aq[i]]);
        core_req <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            core_addr <= aq[3] ^ 15'(k);
            @(negedge clk);
            s0 = n_stall;
            access16(1'b1, {1'b0, aq[3]}, shadow[aq[3]]);
            check({15'h0, n_stall != s0}, {15'h0, k == 0});
        end
        core_req <= 1'b0;
        do_reset(1'b0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            hbh_en <= 1'(k);
            repeat (3) @(negedge clk);
            check({15'h0, holder}, 16'(k));
        end
        word8(hpi_pkg::SEL_ADDR, 1'b0, 16'h7ffe);
        word8(hpi_pkg::SEL_DATA_INC, 1'b1, 16'h0000);
        check(q, shadow[15'h7ffe]);
        word8(hpi_pkg::SEL_DATA, 1'b1, 16'h0000);
        check(q, shadow[15'h7fff]);
        word8(hpi_pkg::SEL_CTRL, 1'b0, 16'h0002);
        check({14'h0, core_irq, hirq_n}, 16'h3);
        core_write(16'h0002);
        check({15'h0, core_irq}, 16'h0);
        core_write(16'h0004);
        check({15'h0, hirq_n}, 16'h0);
        word8(hpi_pkg::SEL_CTRL, 1'b0, 16'h0004);
        check({15'h0, hirq_n}, 16'h1);
        // Every control byte lands whole, so both halves carry it
        word8(hpi_pkg::SEL_CTRL, 1'b0, 16'h0101);
        bo = 1'b1;
        check({15'h0, core_ctl[hpi_pkg::CTL_BOB]}, 16'h1);
        word8(hpi_pkg::SEL_DATA, 1'b1, 16'h0000);
        check(q, shadow[15'h7fff]);
        word8(hpi_pkg::SEL_DATA, 1'b0, 16'hc3a5);
        check(last_wd, 16'hc3a5);
        word8(hpi_pkg::SEL_DATA_INC, 1'b0, 16'h3c5a);
        check(last_wd, 16'h3c5a);
        word8(hpi_pkg::SEL_ADDR, 1'b1, 16'h0000);
        check(q, 16'h8000);
        // Only byte order set, both interrupt flags clear
        word8(hpi_pkg::SEL_CTRL, 1'b1, 16'h0000);
        check(q, 16'h0001);
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> hpi_mem_model.sv
// Behavioural on-chip memory that answers the port's DMA requests
`timescale 1ns/1ps
`default_nettype none
module hpi_mem_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [14:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output logic [15:0] rdata_out
);
    logic [15:0] mem [0:32767];
    logic [3:0] wait_cnt;

    // =====================================
    // Memory survives reset so a later mode can read earlier writes
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            wait_cnt <= 4'h0;
            rdata_out <= 16'h5a5a;
        end else if (req_in && !ack_out && wait_cnt >= delay_in) begin
            ack_out <= 1'b1;
            wait_cnt <= 4'h0;
            if (we_in) begin
                mem[addr_in] <= wdata_in;
                rdata_out <= ~rdata_out;
            end else begin
                rdata_out <= mem[addr_in];
            end
        end else begin
            ack_out <= 1'b0;
            // Data only valid with ack, so keep it moving otherwise
            rdata_out <= ~rdata_out;
            if (req_in && !ack_out) wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> hpi_pkg.sv
// Package of constants and types for the host port interface
// Overview of operation
// [R1] Width-select pin high selects the 16-bit host interface mode.
// [R2] Width-select pin low selects the 8-bit port with byte-wide data bus.
// [R3] 8-bit mode splits each word into two bytes chosen by byte-half select.
// [R4] 8-bit mode uses address, data and control registers; processor reaches control.
// [R5] Sequential transfers auto-increment the address; random transfers use host address.
// [R6] Interrupt paths exist from processor to host and host to processor.
// [R7] Host accesses reach the whole on-chip RAM range over the DMA bus.
// [R8] Host transfers continue while the core is halted by emulation stop.
// [R9] 16-bit mode is non-multiplexed with a 15-bit address reaching all memory.
// [R10] Ready is deasserted until the internal DMA access completes; host holds cycle.
// [R11] Accesses sync to the processor clock; host wins contention, core waits one cycle (code stalls the core every cycle spent in HPI_DMA on a match).
// [R12] Host must not access during reset; clock must run while processor idles.
// [R13] Host starts accesses with strobes and chip select, direction by read/write.
// [R14] 16-bit mode moves data on 16-bit bus and address on separate bus.
// [R15] Control register is unreachable by the host in non-multiplexed mode.
// [R16] Every non-multiplexed host access launches a DMA read or write.
// [R17] Width-select high keeps the data bus holder active regardless of control bit.
// [R18] Strobe is chip select and either data strobe, sampled on its active edge.
package hpi_pkg;
    // =====================================
    // Widths and codes
    localparam int ADDR_W = 16;
    localparam int MEM_W = 15;
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // Control register fields: bit 0 byte order, bit 1 to-core irq, bit 2 to-host irq
    localparam int CTL_BOB = 0;
    localparam int CTL_CIRQ = 1;
    localparam int CTL_HIRQ = 2;

    typedef enum logic [2:0] {
        HPI_IDLE = 3'b001,
        HPI_DMA = 3'b010,
        HPI_DONE = 3'b100
    } hpi_state_e;
endpackage

// >>> hpi_port.sv
// Host port: 8/16-bit host access to on-chip memory via DMA
`timescale 1ns/1ps
`default_nettype none
module hpi_port (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic width_select_pin_in,
    input wire logic host_chip_select_n_in,
    input wire logic host_data_strobe_one_n_in,
    input wire logic host_data_strobe_two_n_in,
    input wire logic host_rw_direction_in,
    input wire logic byte_half_select_in,
    input wire logic [1:0] host_control_select_in,
    input wire logic [15:0] host_address_bus_in,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe_out,
    output logic host_wait_ready_out,
    output logic host_irq_n_out,
    output logic host_bus_holder_out,
    input wire logic host_bus_holder_enable_in,
    input wire logic core_ctl_wr_in,
    input wire logic [15:0] core_ctl_data_in,
    output logic [15:0] core_ctl_out,
    output logic core_irq_out,
    input wire logic core_req_in,
    input wire logic [14:0] core_addr_in,
    output logic core_stall_out,
    output logic dma_req_out,
    output logic dma_we_out,
    output logic [14:0] dma_addr_out,
    output logic [15:0] dma_wdata_out,
    input wire logic dma_ack_in,
    input wire logic [15:0] dma_rdata_in
);
    // =====================================
    // State
    typedef struct packed {
        hpi_pkg::hpi_state_e fsm;
        logic stb_d;
        logic rw;
        logic [15:0] addr;
        logic [15:0] data;
        logic [15:0] ctl;
        logic first_byte;
        logic inc;
        logic [15:0] dout;
        logic oe;
        logic rdy;
        logic cirq;
        logic hirq_n;
        logic holder;
        logic stall;
        logic dreq;
        logic dwe;
        logic [14:0] daddr;
        logic [15:0] dwdata;
    } hpi_port_s;
    hpi_port_s st_ff;
    hpi_port_s nxt_st;

    logic stb_raw;
    logic stb_s;
    logic wide;
    logic edge_hold_wide;

    // Strobe combined before sync so one edge marks one access
    assign stb_raw = ~host_chip_select_n_in &
        (~host_data_strobe_one_n_in | ~host_data_strobe_two_n_in); // [R13] [R18]
    assign wide = width_select_pin_in;

    hpi_sync u_stb_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(stb_raw),
        .q_out(stb_s)
    );

    // =====================================
    // Next state
    always_comb begin
        logic edge_on;
        logic [15:0] bval;
        logic hi;
        logic core_hirq;
        edge_on = 1'b0;
        bval = 16'h0000;
        hi = 1'b0;
        core_hirq = core_ctl_wr_in & core_ctl_data_in[hpi_pkg::CTL_HIRQ];
        nxt_st = st_ff;
        nxt_st.stb_d = stb_s;
        edge_on = stb_s & ~st_ff.stb_d; // [R11] [R18]
        nxt_st.holder = wide | host_bus_holder_enable_in; // [R17]
        // Host priority: the core stalls for each cycle in HPI_DMA on an address match
        nxt_st.stall = core_req_in & (st_ff.fsm == hpi_pkg::HPI_DMA) &
            (core_addr_in == st_ff.daddr); // [R11]
        if (core_ctl_wr_in) begin
            nxt_st.ctl[hpi_pkg::CTL_BOB] = core_ctl_data_in[hpi_pkg::CTL_BOB];
            if (core_ctl_data_in[hpi_pkg::CTL_HIRQ]) begin
                nxt_st.hirq_n = 1'b0; // [R6]
            end
            if (core_ctl_data_in[hpi_pkg::CTL_CIRQ]) begin
                nxt_st.cirq = 1'b0;
            end
        end
        if (~stb_s) begin
            nxt_st.oe = 1'b0;
        end
        unique case (st_ff.fsm)
            hpi_pkg::HPI_IDLE: begin
                nxt_st.rdy = 1'b1;
                if (edge_on && wide) begin
                    // [R1] [R9] [R14] [R16]
                    nxt_st.rw = host_rw_direction_in;
                    nxt_st.addr = {1'b0, host_address_bus_in[hpi_pkg::MEM_W-1:0]};
                    nxt_st.data = host_data_bus_in;
                    nxt_st.inc = 1'b0;
                    nxt_st.rdy = 1'b0; // [R10]
                    nxt_st.dreq = 1'b1;
                    nxt_st.dwe = ~host_rw_direction_in;
                    nxt_st.daddr = host_address_bus_in[hpi_pkg::MEM_W-1:0]; // [R7]
                    nxt_st.dwdata = host_data_bus_in;
                    nxt_st.fsm = hpi_pkg::HPI_DMA;
                end else if (edge_on) begin
                    // [R2] [R3] [R4]
                    hi = byte_half_select_in ^ st_ff.ctl[hpi_pkg::CTL_BOB];
                    nxt_st.first_byte = ~byte_half_select_in;
                    if (host_rw_direction_in) begin
                        unique case (host_control_select_in)
                            hpi_pkg::SEL_CTRL: bval = st_ff.ctl;
                            hpi_pkg::SEL_ADDR: bval = st_ff.addr;
                            default: bval = st_ff.data;
                        endcase
                        nxt_st.dout = {8'h00, hi ? bval[15:8] : bval[7:0]};
                        nxt_st.oe = 1'b1;
                        // Read completes on second byte; autoincrement then prefetch
                        if (byte_half_select_in &&
                            host_control_select_in[0]) begin
                            nxt_st.inc = host_control_select_in == hpi_pkg::SEL_DATA_INC;
                            if (nxt_st.inc) begin
                                nxt_st.addr = st_ff.addr + 16'h0001; // [R5]
                                nxt_st.rw = 1'b1;
                                nxt_st.dreq = 1'b1;
                                nxt_st.dwe = 1'b0;
                                nxt_st.daddr = nxt_st.addr[hpi_pkg::MEM_W-1:0];
                                nxt_st.fsm = hpi_pkg::HPI_DMA;
                            end
                        end
                    end else begin
                        unique case (host_control_select_in)
                            hpi_pkg::SEL_CTRL: begin
                                nxt_st.ctl[hpi_pkg::CTL_BOB] =
                                    host_data_bus_in[hpi_pkg::CTL_BOB];
                                if (host_data_bus_in[hpi_pkg::CTL_CIRQ]) begin
                                    nxt_st.cirq = 1'b1; // [R6]
                                end
                                // Core raising the host interrupt wins over a clear
                                if (host_data_bus_in[hpi_pkg::CTL_HIRQ] && !core_hirq) begin
                                    nxt_st.hirq_n = 1'b1;
                                end
                            end
                            hpi_pkg::SEL_ADDR: begin
                                if (hi) nxt_st.addr[15:8] = host_data_bus_in[7:0];
                                else nxt_st.addr[7:0] = host_data_bus_in[7:0];
                                if (byte_half_select_in) begin
                                    nxt_st.rw = 1'b1;
                                    nxt_st.dreq = 1'b1;
                                    nxt_st.dwe = 1'b0;
                                    nxt_st.daddr = nxt_st.addr[hpi_pkg::MEM_W-1:0];
                                    nxt_st.fsm = hpi_pkg::HPI_DMA;
                                end
                            end
                            default: begin
                                if (hi) nxt_st.data[15:8] = host_data_bus_in[7:0];
                                else nxt_st.data[7:0] = host_data_bus_in[7:0];
                                if (byte_half_select_in) begin
                                    nxt_st.inc = host_control_select_in == hpi_pkg::SEL_DATA_INC;
                                    nxt_st.rw = 1'b0;
                                    nxt_st.dreq = 1'b1;
                                    nxt_st.dwe = 1'b1;
                                    nxt_st.daddr = st_ff.addr[hpi_pkg::MEM_W-1:0];
                                    nxt_st.dwdata = nxt_st.data;
                                    nxt_st.fsm = hpi_pkg::HPI_DMA;
                                end
                            end
                        endcase
                    end
                end
            end
            hpi_pkg::HPI_DMA: begin
                // Runs regardless of core halt: no link to emulation stop
                nxt_st.rdy = 1'b0; // [R8] [R10]
                if (dma_ack_in) begin
                    nxt_st.dreq = 1'b0;
                    nxt_st.dwe = 1'b0;
                    if (st_ff.rw) begin
                        nxt_st.data = dma_rdata_in;
                        if (wide) begin
                            nxt_st.dout = dma_rdata_in;
                            nxt_st.oe = stb_s;
                        end
                    end else if (st_ff.inc) begin
                        nxt_st.addr = st_ff.addr + 16'h0001; // [R5]
                    end
                    nxt_st.fsm = hpi_pkg::HPI_DONE;
                end
            end
            hpi_pkg::HPI_DONE: begin
                nxt_st.rdy = 1'b1; // [R10]
                nxt_st.fsm = hpi_pkg::HPI_IDLE;
            end
            default: begin
                nxt_st.fsm = hpi_pkg::HPI_IDLE;
            end
        endcase
        // Every entry into a DMA drops ready at once, byte paths too
        if (nxt_st.fsm == hpi_pkg::HPI_DMA) begin
            nxt_st.rdy = 1'b0; // [R10]
        end
        // Flag bits mirrored last so host writes show without lag
        nxt_st.ctl[hpi_pkg::CTL_HIRQ] = ~nxt_st.hirq_n;
        nxt_st.ctl[hpi_pkg::CTL_CIRQ] = nxt_st.cirq;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '{fsm: hpi_pkg::HPI_IDLE, addr: hpi_pkg::ADDR_RST,
                data: hpi_pkg::WORD_RST, ctl: hpi_pkg::WORD_RST, dout: hpi_pkg::WORD_RST,
                hirq_n: 1'b1, rdy: 1'b1, dwdata: hpi_pkg::WORD_RST, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign host_data_bus_out = st_ff.dout;
    assign host_data_bus_oe_out = st_ff.oe;
    assign host_wait_ready_out = st_ff.rdy;
    assign host_irq_n_out = st_ff.hirq_n;
    assign host_bus_holder_out = st_ff.holder;
    assign core_ctl_out = st_ff.ctl;
    assign core_irq_out = st_ff.cirq;
    assign core_stall_out = st_ff.stall;
    assign dma_req_out = st_ff.dreq;
    assign dma_we_out = st_ff.dwe;
    assign dma_addr_out = st_ff.daddr;
    assign dma_wdata_out = st_ff.dwdata;

    // =====================================
    // Checks
    a_ready_low_dma: assert property (@(posedge clk_in) disable iff (rst_in)
        st_ff.fsm == hpi_pkg::HPI_DMA |-> !host_wait_ready_out)
        else $error("ready high during dma"); // [R10]
    a_holder_wide_on: assert property (@(posedge clk_in) disable iff (rst_in)
        $past(width_select_pin_in) && !$past(rst_in) |-> host_bus_holder_out)
        else $error("holder off in wide mode"); // [R17]
    a_wide_launch: assert property (@(posedge clk_in) disable iff (rst_in)
        (stb_s && !st_ff.stb_d && wide && st_ff.fsm == hpi_pkg::HPI_IDLE)
        |=> dma_req_out && !host_wait_ready_out)
        else $error("wide access did not launch dma"); // [R16]
    a_dma_done_rdy: assert property (@(posedge clk_in) disable iff (rst_in)
        (dma_req_out && dma_ack_in) |=> ##1 host_wait_ready_out)
        else $error("ready not restored"); // [R10]
    a_dma_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        (dma_req_out && dma_ack_in) |=> !dma_req_out)
        else $error("dma request held after ack"); // [R16]
    a_wide_addr: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(dma_req_out) && $past(wide) |-> dma_addr_out == $past(host_address_bus_in[14:0]))
        else $error("wrong dma address"); // [R9]
    a_ctl_hidden: assert property (@(posedge clk_in) disable iff (rst_in)
        (edge_hold_wide) |=> $stable(core_ctl_out))
        else $error("control changed in wide mode"); // [R15]
    a_stall_match: assert property (@(posedge clk_in) disable iff (rst_in)
        core_stall_out |-> $past(core_req_in) && $past(st_ff.fsm == hpi_pkg::HPI_DMA))
        else $error("stall without contention"); // [R11]
    assign edge_hold_wide = wide && !core_ctl_wr_in;
endmodule
`default_nettype wire

// >>> hpi_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module hpi_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } hpi_sync_s;
    hpi_sync_s st_ff;
    hpi_sync_s nxt_st;

    always_comb begin
        nxt_st.s1 = d_in;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_out = st_ff.s2;
endmodule
`default_nettype wire
